// file: design/cscx_defines.vh
// Shared constants of the calibration serial command executor
`ifndef CSCX_DEFINES_VH
`define CSCX_DEFINES_VH

// Clock and timing figures
`define CSCX_CLK_HZ 10000000
`define CSCX_CLK_MHZ 10
`define CSCX_BAUD_DEFAULT 9600
`define CSCX_ERASE_TIME_US 6000
`define CSCX_ANALOG_UNIT_US 1000

// Character framing: start, eight data, stop
`define CSCX_FRAME_BITS 4'ha
`define CSCX_LAST_DATA_BIT 3'h7

// Widths
`define CSCX_DIV_W 16

// Lock byte value that opens the serial port
`define CSCX_LOCK_OPEN 8'h00

// Target nibble codes of a command byte
`define CSCX_TGT_DHR0 4'h0
`define CSCX_TGT_DHR1 4'h1
`define CSCX_TGT_DHR2 4'h2
`define CSCX_TGT_DHR3 4'h3
`define CSCX_TGT_CMD 4'h4
`define CSCX_TGT_CALSEL 4'h5
`define CSCX_TGT_EEA0 4'h6
`define CSCX_TGT_EEA1 4'h7
`define CSCX_TGT_EEA2 4'h8
`define CSCX_TGT_RBPTR 4'h9
`define CSCX_TGT_ASRC 4'ha
`define CSCX_TGT_ANALOG_HOLD_TIME 4'hb

// Command codes for the command nibble register
`define CSCX_CMD_LOAD_CAL 4'h0
`define CSCX_CMD_ERASE_ALL 4'h1
`define CSCX_CMD_PAGE_ERASE 4'h2
`define CSCX_CMD_EE_WRITE 4'h3
`define CSCX_CMD_READBACK 4'h4
`define CSCX_CMD_ANALOG 4'h5

// Register port map
`define CSCX_REG_DIV 2'h0
`define CSCX_REG_STATUS 2'h1
`define CSCX_REG_LAST 2'h2
`define CSCX_REG_DHR 2'h3

`endif

// file: design/cscx_serial_engine.v
// Serial character receiver and turnaround transmitter on the data pin
`timescale 1ns/10ps
`include "cscx_defines.vh"
module cscx_serial_engine #(
  parameter DIV_W = `CSCX_DIV_W
) (
  input wire core_clk,
  input wire rst,
  input wire [DIV_W-1:0] bit_div,
  input wire rx_enable,
  input wire rx_pin,
  output reg rx_valid,
  output reg [7:0] rx_byte,
  input wire tx_go,
  input wire [7:0] tx_byte,
  output reg tx_busy,
  output reg tx_out,
  output reg tx_oe
);
  localparam RX_IDLE = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_DATA = 2'h2;
  localparam RX_STOP = 2'h3;
  localparam TX_IDLE = 2'h0;
  localparam TX_GAP = 2'h1;
  localparam TX_SEND = 2'h2;

  reg [1:0] rx_state;
  reg [DIV_W-1:0] rx_cnt;
  reg [2:0] rx_bit;
  reg [7:0] rx_shift;
  reg [1:0] tx_state;
  reg [DIV_W-1:0] tx_cnt;
  reg [3:0] tx_bit;
  reg [9:0] tx_shift;
  wire [DIV_W-1:0] half_div;

  assign half_div = {1'b0, bit_div[DIV_W-1:1]};

  // Receiver: sample mid-bit, LSB first, no parity
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_state <= RX_IDLE;
      rx_cnt <= {DIV_W{1'b0}};
      rx_bit <= 3'h0;
      rx_shift <= 8'h00;
      rx_valid <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      if (!rx_enable) begin
        rx_state <= RX_IDLE; // Line ignored while closed
      end else begin
        case (rx_state)
          RX_IDLE: begin
            if (!rx_pin) begin
              rx_state <= RX_START;
              rx_cnt <= half_div;
            end
          end
          RX_START: begin
            if (rx_cnt == {DIV_W{1'b0}}) begin
              // A glitch shorter than half a bit is dropped here
              rx_state <= rx_pin ? RX_IDLE : RX_DATA;
              rx_cnt <= bit_div;
              rx_bit <= 3'h0;
            end else begin
              rx_cnt <= rx_cnt - 1'b1;
            end
          end
          RX_DATA: begin
            if (rx_cnt == {DIV_W{1'b0}}) begin
              rx_shift <= {rx_pin, rx_shift[7:1]};
              rx_cnt <= bit_div;
              rx_bit <= rx_bit + 1'b1;
              if (rx_bit == `CSCX_LAST_DATA_BIT) begin
                rx_state <= RX_STOP;
              end
            end else begin
              rx_cnt <= rx_cnt - 1'b1;
            end
          end
          default: begin
            if (rx_cnt == {DIV_W{1'b0}}) begin
              rx_state <= RX_IDLE;
              // A low stop bit discards the character
              if (rx_pin) begin
                rx_valid <= 1'b1;
                rx_byte <= rx_shift;
              end
            end else begin
              rx_cnt <= rx_cnt - 1'b1;
            end
          end
        endcase
      end
    end
  end

  // Transmitter: one byte time released, then the frame
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_state <= TX_IDLE;
      tx_cnt <= {DIV_W{1'b0}};
      tx_bit <= 4'h0;
      tx_shift <= 10'h3ff;
      tx_busy <= 1'b0;
      tx_out <= 1'b1;
      tx_oe <= 1'b0;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          tx_oe <= 1'b0;
          tx_out <= 1'b1;
          if (tx_go) begin
            tx_state <= TX_GAP;
            tx_busy <= 1'b1;
            tx_cnt <= bit_div;
            tx_bit <= 4'h0;
            tx_shift <= {1'b1, tx_byte, 1'b0};
          end
        end
        TX_GAP: begin
          if (tx_cnt == {DIV_W{1'b0}}) begin
            tx_cnt <= bit_div;
            tx_bit <= tx_bit + 1'b1;
            if (tx_bit == `CSCX_FRAME_BITS - 1'b1) begin
              tx_state <= TX_SEND;
              tx_bit <= 4'h0;
              tx_oe <= 1'b1;
              tx_out <= tx_shift[0];
              tx_shift <= {1'b1, tx_shift[9:1]};
            end
          end else begin
            tx_cnt <= tx_cnt - 1'b1;
          end
        end
        default: begin
          if (tx_cnt == {DIV_W{1'b0}}) begin
            tx_cnt <= bit_div;
            tx_bit <= tx_bit + 1'b1;
            if (tx_bit == `CSCX_FRAME_BITS - 1'b1) begin
              tx_state <= TX_IDLE;
              tx_busy <= 1'b0;
              tx_oe <= 1'b0;
              tx_out <= 1'b1;
            end else begin
              tx_out <= tx_shift[0];
              tx_shift <= {1'b1, tx_shift[9:1]};
            end
          end else begin
            tx_cnt <= tx_cnt - 1'b1;
          end
        end
      endcase
    end
  end
endmodule // cscx_serial_engine

// file: design/cscx_executor.v
// Command executor of the single-wire calibration interface
//
// Summary of operation
// - Load-cal command copies hold register to selected register
// - Full erase and page erase commands supported
// - Write command programs low hold byte at location
// - Readback drives pointed register as framed byte
// - One byte time released, then start, data, stop
// - Probe command routes selected analog source out
// - Probe held for coded time, then output released
// - Data pin released while probe is on output
// - Characters are start, eight bits LSB first, stop
// - Low nibble is target, high nibble payload
// - Targets zero to three fill hold register nibbles
// - Commands accepted only unlocked or override high
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`include "cscx_defines.vh"
module cscx_executor #(
  parameter DIV_W = `CSCX_DIV_W,
  parameter BAUD = `CSCX_BAUD_DEFAULT,
  parameter ERASE_CYCLES = `CSCX_ERASE_TIME_US * `CSCX_CLK_MHZ,
  parameter ANALOG_UNIT_CYCLES = `CSCX_ANALOG_UNIT_US * `CSCX_CLK_MHZ,
  parameter [3:0] CMD_LOAD_CAL = `CSCX_CMD_LOAD_CAL,
  parameter [3:0] CMD_ERASE_ALL = `CSCX_CMD_ERASE_ALL,
  parameter [3:0] CMD_PAGE_ERASE = `CSCX_CMD_PAGE_ERASE,
  parameter [3:0] CMD_EE_WRITE = `CSCX_CMD_EE_WRITE,
  parameter [3:0] CMD_READBACK = `CSCX_CMD_READBACK,
  parameter [3:0] CMD_ANALOG = `CSCX_CMD_ANALOG,
  parameter [4:0] CAL_SEL_COUNT = 5'h10,
  parameter [4:0] ANALOG_HOLD_TIME_OFFSET = 5'h01
) (
  input wire core_clk,
  input wire rst,
  input wire serial_data_in,
  output reg serial_data_out,
  output reg serial_data_oe,
  input wire [7:0] lock_byte,
  input wire lock_override,
  output reg cal_load,
  output reg [3:0] cal_load_select,
  output reg [15:0] cal_load_data,
  output reg ee_write,
  output reg ee_erase_all,
  output reg ee_erase_page,
  output reg [9:0] ee_addr,
  output reg [7:0] ee_wdata,
  output reg [3:0] readback_pointer,
  input wire [7:0] readback_data,
  output reg analog_route_en,
  output reg [3:0] analog_source_select,
  input wire [1:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata
);
  localparam integer DIV_RESET = (`CSCX_CLK_HZ / BAUD) - 1;
  localparam [31:0] ERASE_LAST = ERASE_CYCLES - 1;
  localparam [31:0] UNIT_LAST = ANALOG_UNIT_CYCLES - 1;

  reg [DIV_W-1:0] bit_div;
  reg [15:0] data_hold_register;
  reg [3:0] command_nibble_reg;
  reg [3:0] cal_register_selector;
  reg [9:0] eeprom_location_reg;
  reg [3:0] analog_hold_time;
  reg [7:0] last_command_byte;
  reg port_open;
  reg erase_busy;
  reg [31:0] erase_cnt;
  reg [31:0] unit_cnt;
  reg [4:0] units_left;
  reg tx_go;
  reg [7:0] tx_byte;
  wire rx_enable;
  wire rx_valid;
  wire [7:0] rx_byte;
  wire tx_busy;
  wire tx_out;
  wire tx_oe;
  wire [3:0] command_target_nibble;
  wire [3:0] command_payload_nibble;

  assign command_target_nibble = rx_byte[3:0];
  assign command_payload_nibble = rx_byte[7:4];

  // Lock state registered for a clean serial gate
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      port_open <= 1'b0;
    end else begin
      port_open <= (lock_byte == `CSCX_LOCK_OPEN) || lock_override;
    end
  end

  // Receive only when open and the wire is free
  assign rx_enable = port_open && !tx_busy && !tx_go && !analog_route_en;

  cscx_serial_engine #(
    .DIV_W(DIV_W)
  ) u_engine (
    .core_clk(core_clk),
    .rst(rst),
    .bit_div(bit_div),
    .rx_enable(rx_enable),
    .rx_pin(serial_data_in),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte),
    .tx_go(tx_go),
    .tx_byte(tx_byte),
    .tx_busy(tx_busy),
    .tx_out(tx_out),
    .tx_oe(tx_oe)
  );

  // Interface register set: a command byte writes one nibble
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      data_hold_register <= 16'h0000;
      command_nibble_reg <= 4'h0;
      cal_register_selector <= 4'h0;
      eeprom_location_reg <= 10'h000;
      readback_pointer <= 4'h0;
      analog_source_select <= 4'h0;
      analog_hold_time <= 4'h0;
      last_command_byte <= 8'h00;
    end else if (rx_valid) begin
      last_command_byte <= rx_byte;
      if (command_target_nibble == `CSCX_TGT_DHR0) begin
        data_hold_register[3:0] <= command_payload_nibble;
      end else if (command_target_nibble == `CSCX_TGT_DHR1) begin
        data_hold_register[7:4] <= command_payload_nibble;
      end else if (command_target_nibble == `CSCX_TGT_DHR2) begin
        data_hold_register[11:8] <= command_payload_nibble;
      end else if (command_target_nibble == `CSCX_TGT_DHR3) begin
        data_hold_register[15:12] <= command_payload_nibble;
      end else if (command_target_nibble == `CSCX_TGT_CMD) begin
        command_nibble_reg <= command_payload_nibble;
      end else if (command_target_nibble == `CSCX_TGT_CALSEL) begin
        cal_register_selector <= command_payload_nibble;
      end else if (command_target_nibble == `CSCX_TGT_EEA0) begin
        eeprom_location_reg[3:0] <= command_payload_nibble;
      end else if (command_target_nibble == `CSCX_TGT_EEA1) begin
        eeprom_location_reg[7:4] <= command_payload_nibble;
      end else if (command_target_nibble == `CSCX_TGT_EEA2) begin
        // Only two bits of the top nibble exist
        eeprom_location_reg[9:8] <= command_payload_nibble[1:0];
      end else if (command_target_nibble == `CSCX_TGT_RBPTR) begin
        readback_pointer <= command_payload_nibble;
      end else if (command_target_nibble == `CSCX_TGT_ASRC) begin
        analog_source_select <= command_payload_nibble;
      end else if (command_target_nibble == `CSCX_TGT_ANALOG_HOLD_TIME) begin
        analog_hold_time <= command_payload_nibble;
      end
    end
  end

  // Command strobe; codes are parameters
  wire cmd_strobe;
  assign cmd_strobe = rx_valid && (command_target_nibble == `CSCX_TGT_CMD);

  // Calibration load and EEPROM strobes, one cycle each
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cal_load <= 1'b0;
      cal_load_select <= 4'h0;
      cal_load_data <= 16'h0000;
      ee_write <= 1'b0;
      ee_erase_all <= 1'b0;
      ee_erase_page <= 1'b0;
      ee_addr <= 10'h000;
      ee_wdata <= 8'h00;
    end else begin
      cal_load <= 1'b0;
      ee_write <= 1'b0;
      ee_erase_all <= 1'b0;
      ee_erase_page <= 1'b0;
      if (cmd_strobe) begin
        if (command_payload_nibble == CMD_LOAD_CAL &&
            {1'b0, cal_register_selector} < CAL_SEL_COUNT) begin
          cal_load <= 1'b1;
          cal_load_select <= cal_register_selector;
          cal_load_data <= data_hold_register;
        end else if (command_payload_nibble == CMD_ERASE_ALL) begin
          ee_erase_all <= 1'b1;
        end else if (command_payload_nibble == CMD_PAGE_ERASE) begin
          ee_erase_page <= 1'b1;
          ee_addr <= eeprom_location_reg;
        end else if (command_payload_nibble == CMD_EE_WRITE) begin
          // No erase check: erasing is the host's job
          ee_write <= 1'b1;
          ee_addr <= eeprom_location_reg;
          ee_wdata <= data_hold_register[7:0];
        end
      end
    end
  end

  // Erase timer, shown in status as the settle window
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      erase_busy <= 1'b0;
      erase_cnt <= 32'h00000000;
    end else if (cmd_strobe && (command_payload_nibble == CMD_ERASE_ALL ||
                                command_payload_nibble == CMD_PAGE_ERASE)) begin
      erase_busy <= 1'b1;
      erase_cnt <= 32'h00000000;
    end else if (erase_busy) begin
      if (erase_cnt == ERASE_LAST) begin
        erase_busy <= 1'b0;
      end else begin
        erase_cnt <= erase_cnt + 32'h00000001;
      end
    end
  end

  // Readback: capture pointed data, start the reply
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_go <= 1'b0;
      tx_byte <= 8'h00;
    end else begin
      tx_go <= 1'b0;
      if (cmd_strobe && command_payload_nibble == CMD_READBACK && !tx_busy) begin
        tx_go <= 1'b1;
        tx_byte <= readback_data;
      end
    end
  end

  // Analog probe: hold (code + offset) units, then release
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      analog_route_en <= 1'b0;
      unit_cnt <= 32'h00000000;
      units_left <= 5'h00;
    end else if (cmd_strobe && command_payload_nibble == CMD_ANALOG) begin
      analog_route_en <= 1'b1;
      unit_cnt <= 32'h00000000;
      units_left <= {1'b0, analog_hold_time} + ANALOG_HOLD_TIME_OFFSET - 5'h01;
    end else if (analog_route_en) begin
      if (unit_cnt == UNIT_LAST) begin
        unit_cnt <= 32'h00000000;
        if (units_left == 5'h00) begin
          analog_route_en <= 1'b0;
        end else begin
          units_left <= units_left - 5'h01;
        end
      end else begin
        unit_cnt <= unit_cnt + 32'h00000001;
      end
    end
  end

  // Pin drivers: data pin quiet while a probe owns the wire
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      serial_data_out <= 1'b1;
      serial_data_oe <= 1'b0;
    end else begin
      serial_data_out <= tx_out;
      serial_data_oe <= tx_oe && !analog_route_en;
    end
  end

  // Register port: writes take effect at once
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bit_div <= DIV_RESET[DIV_W-1:0];
    end else if (reg_wr && reg_addr == `CSCX_REG_DIV) begin
      // Zero would run the bit timer at full speed, one cycle per bit; minimum is one
      bit_div <= (reg_wdata[DIV_W-1:0] == {DIV_W{1'b0}}) ? {{(DIV_W-1){1'b0}}, 1'b1} : reg_wdata[DIV_W-1:0];
    end
  end

  // Read data stand one cycle after the strobe
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr == `CSCX_REG_DIV) begin
        reg_rdata <= bit_div;
      end else if (reg_addr == `CSCX_REG_STATUS) begin
        reg_rdata <= {12'h000, analog_route_en, tx_busy, erase_busy, port_open};
      end else if (reg_addr == `CSCX_REG_LAST) begin
        reg_rdata <= {8'h00, last_command_byte};
      end else begin
        reg_rdata <= data_hold_register;
      end
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule // cscx_executor

// file: dv/cscx_executor_props.sv
// Port assertions for the calibration command executor
`timescale 1ns/10ps
module cscx_executor_props #(
  parameter ANALOG_UNIT_CYCLES = 10000
) (
  input wire core_clk,
  input wire rst,
  input wire serial_data_out,
  input wire serial_data_oe,
  input wire [7:0] lock_byte,
  input wire lock_override,
  input wire cal_load,
  input wire [15:0] cal_load_data,
  input wire ee_write,
  input wire ee_erase_all,
  input wire ee_erase_page,
  input wire [9:0] ee_addr,
  input wire analog_route_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Probe length counter; too long for a repetition
  reg [31:0] probe_len;
  always @(posedge core_clk or posedge rst) begin
    if (rst)
      probe_len <= 32'h0;
    else if (analog_route_en)
      probe_len <= probe_len + 32'h1;
    else
      probe_len <= 32'h0;
  end
  wire locked = (lock_byte != 8'h00) && !lock_override;
  wire any_cmd = cal_load || ee_write || ee_erase_all || ee_erase_page;

  property p_load_pulse; cal_load |=> !cal_load; endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("load pulse too long");
  property p_load_data; $changed(cal_load_data) |-> cal_load; endproperty
  a_load_data: assert property (p_load_data) else $error("load data moved alone");
  property p_addr_hold; $changed(ee_addr) |-> ee_write || ee_erase_page; endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("location moved alone");
  property p_erase_pulse; ee_erase_all |-> !ee_erase_page ##1 !ee_erase_all; endproperty
  a_erase_pulse: assert property (p_erase_pulse) else $error("erase pulse malformed");
  property p_probe_quiet; analog_route_en |-> !serial_data_oe; endproperty
  a_probe_quiet: assert property (p_probe_quiet) else $error("data pin driven during probe");
  property p_probe_units;
    $fell(analog_route_en) |-> probe_len != 0 && probe_len % ANALOG_UNIT_CYCLES == 0;
  endproperty
  a_probe_units: assert property (p_probe_units) else $error("probe length not whole units");
  property p_start_low; $rose(serial_data_oe) |-> ##[0:1] !serial_data_out; endproperty
  a_start_low: assert property (p_start_low) else $error("reply lacks start bit");
  property p_stop_high; $fell(serial_data_oe) |-> $past(serial_data_out); endproperty
  a_stop_high: assert property (p_stop_high) else $error("reply lacks stop bit");
  // Eight locked cycles flush commands in flight
  property p_locked; locked [*8] |=> !any_cmd && !$rose(analog_route_en); endproperty
  a_locked: assert property (p_locked) else $error("command while locked");

  c_load: cover property (cal_load);
  c_write: cover property (ee_write);
  c_reply: cover property ($rose(serial_data_oe));
  c_probe: cover property ($fell(analog_route_en));
endmodule // cscx_executor_props

bind cscx_executor cscx_executor_props #(.ANALOG_UNIT_CYCLES(ANALOG_UNIT_CYCLES)) cscx_executor_props_inst (
  .core_clk(core_clk), .rst(rst), .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
  .lock_byte(lock_byte), .lock_override(lock_override), .cal_load(cal_load), .cal_load_data(cal_load_data),
  .ee_write(ee_write), .ee_erase_all(ee_erase_all), .ee_erase_page(ee_erase_page), .ee_addr(ee_addr),
  .analog_route_en(analog_route_en));

// file: dv/cscx_host_model.sv
// Behavioural host tester on the shared serial data wire
`timescale 1ns/10ps
module cscx_host_model (
  input wire core_clk,
  input wire line_level,
  input wire [15:0] bit_cycles,
  output reg host_out,
  output reg host_oe
);
  initial begin
    host_out = 1'b1;
    host_oe = 1'b0;
  end
  // Start, eight bits LSB first, stop; then let go
  task send_byte(input [7:0] b);
    reg [9:0] f;
    integer i;
    integer k;
    begin
      f = {1'b1, b, 1'b0};
      for (i = 0; i < 10; i = i + 1) begin
        @(posedge core_clk);
        host_oe <= 1'b1;
        host_out <= f[i];
        for (k = 1; k < bit_cycles; k = k + 1)
          @(posedge core_clk);
      end
      @(posedge core_clk);
      host_oe <= 1'b0;
      host_out <= 1'b0;
    end
  endtask
  // Target nibble goes out first
  task put(input [3:0] tgt, input [3:0] val);
    begin
      send_byte({val, tgt});
      repeat (2) @(posedge core_clk);
    end
  endtask
  // Samples on falling edges, away from pin changes
  task recv_byte(output [7:0] b, output integer gap, output reg ok);
    integer i;
    begin
      gap = 0;
      while (line_level === 1'b1 && gap < 4000) begin
        @(negedge core_clk);
        gap = gap + 1;
      end
      repeat (bit_cycles / 2) @(negedge core_clk);
      ok = (line_level === 1'b0);
      for (i = 0; i < 8; i = i + 1) begin
        repeat (bit_cycles) @(negedge core_clk);
        b[i] = line_level;
      end
      repeat (bit_cycles) @(negedge core_clk);
      ok = ok && (line_level === 1'b1);
    end
  endtask
endmodule // cscx_host_model

// file: dv/cscx_executor_bench.sv
// Self-checking bench for the calibration command executor
`timescale 1ns/10ps
module cscx_executor_bench;
  reg core_clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] lock_byte = 8'h00;
  reg lock_override = 1'b0;
  reg [7:0] readback_data;
  reg [1:0] reg_addr = 2'h0;
  reg [15:0] reg_wdata = 16'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [15:0] bit_cycles = 16'h8;
  wire serial_data_out, serial_data_oe, cal_load, ee_write, ee_erase_all, ee_erase_page, analog_route_en;
  wire [3:0] cal_load_select, readback_pointer, analog_source_select;
  wire [15:0] cal_load_data, reg_rdata;
  wire [9:0] ee_addr;
  wire [7:0] ee_wdata;
  wire host_out, host_oe;
  // Pull-up: released by both sides the wire reads high
  wire line_level = host_oe ? host_out : (serial_data_oe ? serial_data_out : 1'b1);
  integer failures = 0;
  integer total_checks = 0;
  integer n_load = 0, n_wr = 0, n_ea = 0, n_ep = 0, en_len = 0, en_last = 0;
  integer n, gap;
  logic [15:0] rd;
  logic [7:0] rx;
  reg ok;

  always #50 core_clk = ~core_clk;
  // Readback source: a pattern naming the pointer
  always @* readback_data = {4'ha, readback_pointer};

  cscx_executor #(.ERASE_CYCLES(50), .ANALOG_UNIT_CYCLES(20), .CAL_SEL_COUNT(5'h0c)) cscx_executor_inst (
    .core_clk(core_clk), .rst(rst), .serial_data_in(line_level), .serial_data_out(serial_data_out),
    .serial_data_oe(serial_data_oe), .lock_byte(lock_byte), .lock_override(lock_override),
    .cal_load(cal_load), .cal_load_select(cal_load_select), .cal_load_data(cal_load_data),
    .ee_write(ee_write), .ee_erase_all(ee_erase_all), .ee_erase_page(ee_erase_page), .ee_addr(ee_addr),
    .ee_wdata(ee_wdata), .readback_pointer(readback_pointer), .readback_data(readback_data),
    .analog_route_en(analog_route_en), .analog_source_select(analog_source_select), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  cscx_host_model host (.core_clk(core_clk), .line_level(line_level), .bit_cycles(bit_cycles),
    .host_out(host_out), .host_oe(host_oe));

  // Pulses counted here so a late poll cannot miss them
  always @(posedge core_clk) begin
    if (cal_load === 1'b1) n_load = n_load + 1;
    if (ee_write === 1'b1) n_wr = n_wr + 1;
    if (ee_erase_all === 1'b1) n_ea = n_ea + 1;
    if (ee_erase_page === 1'b1) n_ep = n_ep + 1;
    if (analog_route_en === 1'b1) en_len = en_len + 1;
    else if (en_len != 0) begin
      en_last = en_len;
      en_len = 0;
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
      end
    end
  endtask
  task reg_write(input [1:0] a, input [15:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  // Read data stand one cycle after the strobe
  task reg_read(input [1:0] a, output [15:0] d);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      d = reg_rdata;
      @(posedge core_clk);
    end
  endtask
  task t_reset;
    begin
      check(serial_data_oe, 1'b0, "pin released");
      reg_read(2'h0, rd);
      check(rd, 16'h0410, "divider reset");
      reg_read(2'h1, rd);
      check(rd, 16'h0001, "status reset");
      $display("Test reset done");
    end
  endtask
  task t_regs;
    begin
      reg_write(2'h0, 16'h0000);
      reg_read(2'h0, rd);
      check(rd, 16'h0001, "divider floor");
      reg_write(2'h0, 16'h0007);
      reg_write(2'h1, 16'hffff);
      reg_write(2'h3, 16'hffff);
      reg_read(2'h0, rd);
      check(rd, 16'h0007, "divider");
      @(negedge core_clk);
      check(reg_rdata, 16'h0000, "read data one cycle");
      @(posedge core_clk);
      reg_read(2'h1, rd);
      check(rd, 16'h0001, "status read only");
      reg_read(2'h3, rd);
      check(rd, 16'h0000, "hold read only");
      $display("Test registers done");
    end
  endtask
  task t_load;
    begin
      host.put(4'h0, 4'h4);
      host.put(4'h1, 4'h3);
      host.put(4'h2, 4'h2);
      host.put(4'h3, 4'h1);
      host.put(4'h5, 4'h9);
      reg_read(2'h3, rd);
      check(rd, 16'h1234, "hold nibbles");
      n = n_load;
      host.put(4'h4, 4'h0);
      check(n_load, n + 1, "load pulse");
      check(cal_load_select, 4'h9, "selector");
      check(cal_load_data, 16'h1234, "load data");
      reg_read(2'h2, rd);
      check(rd, 16'h0004, "last byte");
      // Selector past the last register loads nothing
      host.put(4'h5, 4'hd);
      host.put(4'h4, 4'h0);
      check(n_load, n + 1, "selector out of range");
      $display("Test load done");
    end
  endtask
  task t_eeprom;
    begin
      host.put(4'h6, 4'h1);
      host.put(4'h7, 4'h6);
      host.put(4'h8, 4'h1);
      host.put(4'h4, 4'h1);
      check(n_ea, 1, "full erase");
      check(ee_addr, 10'h000, "location not pushed");
      reg_read(2'h1, rd);
      check(rd, 16'h0003, "erase busy");
      repeat (50) @(posedge core_clk);
      reg_read(2'h1, rd);
      check(rd, 16'h0001, "erase done");
      host.put(4'h4, 4'h2);
      check(n_ep, 1, "page erase");
      check(ee_addr, 10'h161, "page location");
      // Two hold nibbles outlast the erase wait
      host.put(4'h0, 4'ha);
      host.put(4'h1, 4'ha);
      host.put(4'h4, 4'h3);
      check(n_wr, 1, "byte write");
      check(ee_addr, 10'h161, "write location");
      check(ee_wdata, 8'haa, "write data");
      $display("Test eeprom done");
    end
  endtask
  task t_readback;
    begin
      host.put(4'h9, 4'h6);
      check(readback_pointer, 4'h6, "pointer");
      host.put(4'h4, 4'h4);
      host.recv_byte(rx, gap, ok);
      check(rx, 8'ha6, "reply byte");
      check(ok, 1'b1, "reply framing");
      check(gap >= 72 && gap <= 88, 1'b1, "turnaround");
      repeat (12) @(posedge core_clk);
      $display("Test readback done");
    end
  endtask
  task t_probe;
    begin
      host.put(4'ha, 4'h3);
      host.put(4'hb, 4'h1);
      host.put(4'h4, 4'h5);
      check(analog_source_select, 4'h3, "probe source");
      check(analog_route_en, 1'b1, "probe active");
      check(serial_data_oe, 1'b0, "pin released in probe");
      repeat (60) @(posedge core_clk);
      check(en_last, 40, "probe hold time");
      $display("Test probe done");
    end
  endtask
  task t_lock;
    begin
      host.put(4'h5, 4'h2);
      n = n_load;
      lock_byte <= 8'h5a;
      repeat (2) @(posedge core_clk);
      reg_read(2'h1, rd);
      check(rd, 16'h0000, "port closed");
      host.put(4'h4, 4'h0);
      check(n_load, n, "locked command");
      lock_override <= 1'b1;
      repeat (2) @(posedge core_clk);
      host.put(4'h4, 4'h0);
      check(n_load, n + 1, "override command");
      check(cal_load_select, 4'h2, "override selector");
      $display("Test lock done");
    end
  endtask
  task close_out;
    begin
      $display("Checks %0d, mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  // Watchdog: about thirteen times the expected run
  initial begin
    #3000000;
    failures = failures + 1;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out;
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset;
    t_regs;
    t_load;
    t_eeprom;
    t_readback;
    t_probe;
    t_lock;
    close_out;
  end
endmodule // cscx_executor_bench
